// *** pscd_pkg.sv ***
// Package for the program and system control decoder
// Assumes a 12-bit instruction word, 11-bit counter, one core clock

package pscd_pkg;

  localparam int PC_W    = 11;
  localparam int STK_D   = 8;

  // ************************************
  // Opcodes
  // ************************************
  localparam logic [11:0] OP_IDLE        = 12'h000;
  localparam logic [11:0] OP_POWER_DOWN  = 12'h003;
  localparam logic [11:0] OP_EXIT        = 12'h00C;
  localparam logic [11:0] OP_EXIT_FAR    = 12'h00D;
  localparam logic [11:0] OP_INT_EXIT    = 12'h00E;
  localparam logic [11:0] OP_INT_EXIT_AD = 12'h00F;
  localparam logic [11:0] OP_FETCH       = 12'h041;
  localparam logic [8:0]  OP_PSEG_PFX    = 9'h002;   // 0000 0001 0nnn
  localparam logic [8:0]  OP_RSEG_PFX    = 9'h003;   // 0000 0001 1nnn
  localparam logic [3:0]  OP_INVOKE_PFX  = 4'h9;
  localparam logic [3:0]  OP_EXIT_LIT_PFX = 4'h8;
  localparam logic [2:0]  OP_BRANCH_PFX  = 3'h5;
  localparam logic [6:0]  OP_MOVFW_PFX   = 7'h01;    // 0000 001f ffff
  localparam logic [6:0]  OP_ADDFW_PFX   = 7'h0F;    // 0001 111f ffff
  localparam logic [3:0]  OP_SKIP_CLR    = 4'h6;     // 0110 bbbf ffff
  localparam logic [3:0]  OP_SKIP_SET    = 4'h7;     // 0111 bbbf ffff

  localparam logic [4:0]  FA_PC     = 5'h02;
  localparam logic [4:0]  FA_STATUS = 5'h03;
  localparam int          CARRY_BIT = 0;
  localparam int          SEG_LO    = 5;

  // ************************************
  // Cycle counts (compatible / turbo)
  // ************************************
  localparam logic [2:0] CYC_ONE       = 3'h1;
  localparam logic [2:0] CYC_FLOW_C    = 3'h2;
  localparam logic [2:0] CYC_FLOW_T    = 3'h3;
  localparam logic [2:0] CYC_FETCH_C   = 3'h1;
  localparam logic [2:0] CYC_FETCH_T   = 3'h4;
  localparam logic [2:0] CYC_IND_C     = 3'h4;
  localparam logic [2:0] CYC_IND_T     = 3'h3;
  localparam logic [2:0] CYC_SKIP_TRUE = 3'h2;
  localparam logic [2:0] CYC_PCSKIP_C  = 3'h4;
  localparam logic [2:0] CYC_PCSKIP_T  = 3'h2;

  // Shadow image restored on interrupt exit
  typedef struct packed {
    logic [7:0]      acc;
    logic [7:0]      status;
    logic [7:0]      fsp;
    logic [PC_W-1:0] pc;
  } pscd_shadow_t;

  typedef enum logic [1:0] {
    ST_ISSUE = 2'b00,
    ST_HOLD  = 2'b01
  } pscd_state_t;

endpackage : pscd_pkg

// *** pscd_stack.sv ***
// Hardware return stack for the control decoder
// Assumes push and pop never coincide
`timescale 1ns/100ps
module pscd_stack #(
  parameter int W = 11,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] top
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] ptr;

  // Overflow wraps, oldest entry lost
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr <= '0;
    end else if (push) begin
      ptr <= ptr + 1'b1;
    end else if (pop) begin
      ptr <= ptr - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr] <= din;
    end
  end

  assign top = mem[ptr - 1'b1];
endmodule : pscd_stack

// *** pscd_core.sv ***
// Program and system control decoder with AHB-Lite register access
// Assumes one bus master, synchronous instruction stream, 25 MHz clock
`timescale 1ns/100ps
module pscd_core
  import pscd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             osc_stop,
  output logic             prescaler_clear,
  output logic             busy
);
  import pscd_pkg::*;

  // ************************************
  // Register map
  // ************************************
  localparam logic [7:0] A_INSTR  = 8'h00;
  localparam logic [7:0] A_CTRL   = 8'h04;
  localparam logic [7:0] A_PC     = 8'h08;
  localparam logic [7:0] A_ACC    = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_FSP    = 8'h14;
  localparam logic [7:0] A_MODE   = 8'h18;
  localparam logic [7:0] A_RTC    = 8'h1C;
  localparam logic [7:0] A_WDOG   = 8'h20;
  localparam logic [7:0] A_SHADOW = 8'h24;
  localparam logic [7:0] A_PMEM   = 8'h28;
  localparam logic [7:0] A_CYC    = 8'h2C;
  localparam int TO_BIT = 4;
  localparam int PD_BIT = 3;

  logic [PC_W-1:0] pc;
  logic [7:0]      acc, status, fsp, rtc, wdog;
  logic [3:0]      mode;
  logic            turbo, psc_wdog;
  pscd_shadow_t    shadow;
  logic [11:0]     pmem_word;
  pscd_state_t     state;
  logic [2:0]      remain, last_cyc;
  logic [PC_W-1:0] stk_top;
  logic            push, pop;

  // Bus address phase capture
  logic       ap_wr, ap_rd;
  logic [7:0] ap_addr;
  wire  take = hsel & hready & htrans[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      ap_wr   <= 1'b0;
      ap_rd   <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_wr   <= take & hwrite;
      ap_rd   <= take & ~hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  // Instruction issued on a write of A_INSTR while idle
  wire        issue = ap_wr && ap_addr == A_INSTR && state == ST_ISSUE;
  wire [11:0] op    = hwdata[11:0];

  // ************************************
  // Decode
  // ************************************
  wire d_invoke  = op[11:8] == OP_INVOKE_PFX;
  wire d_branch  = op[11:9] == OP_BRANCH_PFX;
  wire d_exitlit = op[11:8] == OP_EXIT_LIT_PFX;
  wire d_exit    = op == OP_EXIT;
  wire d_exitfar = op == OP_EXIT_FAR;
  wire d_iexit   = op == OP_INT_EXIT;
  wire d_iexitad = op == OP_INT_EXIT_AD;
  wire d_fetch   = op == OP_FETCH;
  wire d_pseg    = op[11:3] == OP_PSEG_PFX;
  wire d_rseg    = op[11:3] == OP_RSEG_PFX;
  wire d_pdown   = op == OP_POWER_DOWN;
  wire d_ind     = (op[11:5] == OP_MOVFW_PFX || op[11:5] == OP_ADDFW_PFX)
                   && op[4:0] == FA_PC;
  wire d_skip    = op[11:8] == OP_SKIP_CLR || op[11:8] == OP_SKIP_SET;
  wire d_sub_ret = d_exit | d_exitfar | d_exitlit;

  // Bit under test, carry at status bit 0
  logic tbit;
  always_comb begin
    tbit = 1'b0;
    if (op[4:0] == FA_STATUS) begin
      tbit = status[op[7:5]];
    end else if (op[4:0] == FA_PC) begin
      tbit = pc[op[7:5]];
    end
  end
  wire skip_true = (op[8] == 1'b1) ? tbit : ~tbit;
  wire pc_skip   = d_skip && op[4:0] == FA_PC && op[7:5] == 3'd0;

  // Cycle count from issue mode
  logic [2:0] cyc;
  always_comb begin
    cyc = CYC_ONE;
    if (d_invoke | d_branch | d_sub_ret | d_iexit | d_iexitad) begin
      cyc = turbo ? CYC_FLOW_T : CYC_FLOW_C;
    end else if (d_fetch) begin
      cyc = turbo ? CYC_FETCH_T : CYC_FETCH_C;
    end else if (d_ind) begin
      cyc = turbo ? CYC_IND_T : CYC_IND_C;
    end else if (pc_skip) begin
      cyc = turbo ? CYC_PCSKIP_T : CYC_PCSKIP_C;
    end else if (d_skip) begin
      cyc = skip_true ? CYC_SKIP_TRUE : CYC_ONE;
    end
  end

  assign push = issue & d_invoke;
  assign pop  = issue & d_sub_ret;

  pscd_stack #(.W(PC_W), .D(STK_D)) u_stack (
    .clk  (clk),
    .rst  (rst),
    .push (push),
    .pop  (pop),
    .din  (pc + 1'b1),
    .top  (stk_top)
  );

  // ************************************
  // Busy sequencer
  // ************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= ST_ISSUE;
      remain   <= 3'h0;
      last_cyc <= 3'h0;
    end else if (issue) begin
      last_cyc <= cyc;
      remain   <= cyc - 1'b1;
      state    <= (cyc > CYC_ONE) ? ST_HOLD : ST_ISSUE;
    end else if (state == ST_HOLD) begin
      remain <= remain - 1'b1;
      if (remain == 3'h1) begin
        state <= ST_ISSUE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= issue ? (cyc > CYC_ONE) : (state == ST_HOLD && remain != 3'h1);
    end
  end

  // ************************************
  // Program counter and page bits
  // ************************************
  wire sw_wr = ap_wr & (state == ST_ISSUE);
  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= '0;
    end else if (issue) begin
      if (d_invoke) begin
        pc <= {status[6:5], 1'b0, op[7:0]};
      end else if (d_branch) begin
        pc <= {status[6:5], op[8:0]};
      end else if (d_sub_ret) begin
        pc <= stk_top;
      end else if (d_iexit | d_iexitad) begin
        pc <= shadow.pc;
      end else if (d_ind) begin
        pc <= (op[11:5] == OP_ADDFW_PFX) ? {pc[10:8], pc[7:0] + acc}
                                         : {pc[10:8], acc};
      end else if (d_skip && skip_true) begin
        pc <= pc + 11'd2;
      end else begin
        pc <= pc + 1'b1;
      end
    end else if (sw_wr && ap_addr == A_PC) begin
      pc <= hwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= 8'h18;
    end else if (issue && d_exitfar) begin
      status[6:5] <= stk_top[10:9];
    end else if (issue && (d_iexit | d_iexitad)) begin
      status <= shadow.status;
    end else if (issue && d_pseg) begin
      status[7:SEG_LO] <= op[2:0];
    end else if (issue && d_pdown) begin
      status[TO_BIT] <= 1'b1;
      status[PD_BIT] <= 1'b0;
    end else if (sw_wr && ap_addr == A_STATUS) begin
      status <= hwdata[7:0];
    end
  end

  // Accumulator, mode, pointer, timer
  always_ff @(posedge clk) begin
    if (rst) begin
      acc  <= 8'h00;
      mode <= 4'h0;
    end else if (issue && d_exitlit) begin
      acc <= op[7:0];
    end else if (issue && (d_iexit | d_iexitad)) begin
      acc <= shadow.acc;
    end else if (issue && d_fetch) begin
      {mode, acc} <= pmem_word;
    end else if (sw_wr && ap_addr == A_ACC) begin
      acc <= hwdata[7:0];
    end else if (sw_wr && ap_addr == A_MODE) begin
      mode <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fsp <= 8'h00;
    end else if (issue && d_rseg) begin
      fsp[7:SEG_LO] <= op[2:0];
    end else if (issue && (d_iexit | d_iexitad)) begin
      fsp <= shadow.fsp;
    end else if (sw_wr && ap_addr == A_FSP) begin
      fsp <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rtc <= 8'h00;
    end else if (issue && d_iexitad) begin
      rtc <= rtc + acc;
    end else if (sw_wr && ap_addr == A_RTC) begin
      rtc <= hwdata[7:0];
    end
  end

  // Shadow, fetch source and mode bits are loaded by software
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow    <= '0;
      pmem_word <= 12'h000;
      turbo     <= 1'b0;
      psc_wdog  <= 1'b0;
    end else if (sw_wr && ap_addr == A_SHADOW) begin
      // Image wider than the bus word, top accumulator bits read as zero
      shadow <= {{($bits(pscd_shadow_t) - 32){1'b0}}, hwdata};
    end else if (sw_wr && ap_addr == A_PMEM) begin
      pmem_word <= hwdata[11:0];
    end else if (sw_wr && ap_addr == A_CTRL) begin
      turbo    <= hwdata[0];
      psc_wdog <= hwdata[1];
    end
  end

  // Power-down side effects
  always_ff @(posedge clk) begin
    if (rst) begin
      wdog            <= 8'h00;
      osc_stop        <= 1'b0;
      prescaler_clear <= 1'b0;
    end else begin
      prescaler_clear <= issue & d_pdown & psc_wdog;
      if (issue && d_pdown) begin
        wdog     <= 8'h00;
        osc_stop <= 1'b1;
      end else if (sw_wr && ap_addr == A_WDOG) begin
        wdog     <= hwdata[7:0];
        osc_stop <= 1'b0;
      end else if (sw_wr && ap_addr == A_CTRL) begin
        osc_stop <= 1'b0;
      end
    end
  end

  // ************************************
  // Read mux
  // ************************************
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      A_CTRL:   rd_word = {30'h0, psc_wdog, turbo};
      A_PC:     rd_word = {21'h0, pc};
      A_ACC:    rd_word = {24'h0, acc};
      A_STATUS: rd_word = {24'h0, status};
      A_FSP:    rd_word = {24'h0, fsp};
      A_MODE:   rd_word = {28'h0, mode};
      A_RTC:    rd_word = {24'h0, rtc};
      A_WDOG:   rd_word = {24'h0, wdog};
      A_CYC:    rd_word = {28'h0, busy, last_cyc};
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ************************************
  // Checks
  // ************************************
  AST_INVOKE_PC: assert property (@(posedge clk) disable iff (rst)
    issue && d_invoke |=> pc[7:0] == $past(op[7:0]) && !pc[8])
    else $error("invoke target wrong");
  AST_BRANCH_PC: assert property (@(posedge clk) disable iff (rst)
    issue && d_branch |=> pc[8:0] == $past(op[8:0]))
    else $error("branch target wrong");
  AST_RET_PC: assert property (@(posedge clk) disable iff (rst)
    issue && d_exit |=> pc == $past(stk_top))
    else $error("exit target wrong");
  AST_FLOW_CYC: assert property (@(posedge clk) disable iff (rst)
    issue && d_branch && turbo |=> busy [*2] ##1 !busy)
    else $error("turbo flow timing wrong");
  AST_RSEG: assert property (@(posedge clk) disable iff (rst)
    issue && d_rseg |=> fsp[7:5] == $past(op[2:0]) && !busy)
    else $error("segment load wrong");
  AST_PSEG: assert property (@(posedge clk) disable iff (rst)
    issue && d_pseg |=> status[7:5] == $past(op[2:0]))
    else $error("page load wrong");
  AST_PDOWN: assert property (@(posedge clk) disable iff (rst)
    issue && d_pdown |=> wdog == 8'h00 && status[TO_BIT] && !status[PD_BIT] && osc_stop)
    else $error("power-down effects wrong");
  AST_IND_CYC: assert property (@(posedge clk) disable iff (rst)
    issue && d_ind && !turbo |=> busy [*3] ##1 !busy)
    else $error("indirect branch timing wrong");
  AST_RTC_ADJ: assert property (@(posedge clk) disable iff (rst)
    issue && d_iexitad |=> rtc == $past(rtc) + $past(acc))
    else $error("timer adjust wrong");

  COV_INVOKE: cover property (@(posedge clk) issue && d_invoke);
  COV_FETCH_T: cover property (@(posedge clk) issue && d_fetch && turbo);
  COV_SKIP: cover property (@(posedge clk) issue && d_skip && skip_true);
endmodule : pscd_core

// *** pscd_ahb_master.sv ***
// AHB-Lite single word master, the bus partner of the decoder
// Assumes one slave whose hreadyout comes back as hready
`timescale 1ns/100ps
module pscd_ahb_master (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  int tmo = 0;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // ************************************
  // One transfer, address then data phase
  // ************************************
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    // Read data belongs to the edge that ends the data phase
    q = hrdata;
    if (n >= 50) begin
      tmo++;
      test_program_system_control_decode.conclude();
    end
  endtask : xfer
endmodule : pscd_ahb_master

// *** test_program_system_control_decode.sv ***
// Self-checking bench for the program and system control decoder
// Assumes the decoder is the only slave behind the bus master model
`timescale 1ns/100ps
module test_program_system_control_decode;
  import pscd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, osc_stop, prescaler_clear, busy;
  logic [31:0] haddr, hwdata, hrdata, sv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_total = 0;
  int          cmp_count = 0;
  int          seed = 32'ha31d_a2e6;
  int          pc = 0;
  int          acc = 0;
  int          st = 8'h18;
  int          fsp = 0;
  int          mode = 0;
  int          rtc = 0;
  int          turbo, pcl, k, v, a;
  int          stk[$];

  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (prescaler_clear === 1'b1) begin
      pcl++;
    end
  end

  pscd_core pscd_core_i (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_stop(osc_stop),
    .prescaler_clear(prescaler_clear), .busy(busy)
  );
  pscd_ahb_master pscd_ahb_master_i (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // ************************************
  // Helpers
  // ************************************
  task automatic conclude;
    err_total += pscd_ahb_master_i.tmo;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] q;
    pscd_ahb_master_i.xfer(1'b1, ad, d, q);
  endtask : wr

  task automatic rchk(input string nm, input logic [31:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    pscd_ahb_master_i.xfer(1'b0, ad, 32'h0000_0000, q);
    chk(nm, exp, q);
  endtask : rchk

  function automatic int fc(input int c, input int t);
    return turbo ? t : c;
  endfunction : fc

  // Issue one opcode, time busy, then compare cycle count, pc, acc, status, fsp and mode
  task automatic run(input logic [11:0] op, input int cyc);
    int n;
    n = 0;
    wr(32'h0000_0000, {20'h0_0000, op});
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy cycles", cyc - 1, n);
    chk("hresp", 0, hresp);
    rchk("cycle count", 32'h0000_002C, cyc);
    rchk("pc", 32'h0000_0008, pc);
    rchk("acc", 32'h0000_000C, acc);
    rchk("status", 32'h0000_0010, st);
    rchk("fsp", 32'h0000_0014, fsp);
    rchk("mode", 32'h0000_0018, mode);
  endtask : run

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("status", 32'h0000_0010, st);
    rchk("unmapped", 32'h0000_0040, 0);
    wr(32'h0000_0040, 32'hFFFF_FFFF);
    rchk("unmapped", 32'h0000_0040, 0);
    for (turbo = 0; turbo < 2; turbo++) begin
      wr(32'h0000_0004, turbo * 3);
      pc = (pc + 1) & 12'h7FF;
      run(OP_IDLE, 1);
      k = $random(seed) & 3'h7;
      st = (st & 8'h1F) | (k << 5);
      pc = (pc + 1) & 12'h7FF;
      run(12'h010 | k, 1);
      k = $random(seed) & 3'h7;
      fsp = (fsp & 8'h1F) | (k << 5);
      pc = (pc + 1) & 12'h7FF;
      run(12'h018 | k, 1);
      k = $random(seed) & 12'h1FF;
      pc = (((st >> 5) & 3) << 9) | k;
      run(12'hA00 | k, fc(2, 3));
      for (int i = 0; i < 3; i++) begin
        k = $random(seed) & 8'hFF;
        stk.push_back((pc + 1) & 12'h7FF);
        pc = (((st >> 5) & 3) << 9) | k;
        run(12'h900 | k, fc(2, 3));
      end
      // New bank so the far exit has something to restore
      st = st ^ 8'h60;
      pc = (pc + 1) & 12'h7FF;
      run(12'h010 | (st >> 5), 1);
      pc = stk.pop_back();
      run(OP_EXIT, fc(2, 3));
      v = stk.pop_back();
      pc = v;
      st = (st & 8'h9F) | (((v >> 9) & 3) << 5);
      run(OP_EXIT_FAR, fc(2, 3));
      k = $random(seed) & 8'hFF;
      acc = k;
      pc = stk.pop_back();
      run(12'h800 | k, fc(2, 3));
      k = $random(seed) & 12'hFFF;
      wr(32'h0000_0028, k);
      mode = k >> 8;
      acc = k & 8'hFF;
      pc = (pc + 1) & 12'h7FF;
      run(OP_FETCH, fc(1, 4));
      for (int i = 0; i < 2; i++) begin
        a = (st & 1) ^ i;
        pc = (pc + 1 + a) & 12'h7FF;
        run(i ? 12'h603 : 12'h703, a ? 2 : 1);
      end
      k = pc & 1;
      pc = (pc + 2) & 12'h7FF;
      run(k ? 12'h702 : 12'h602, fc(4, 2));
      // Indirect move keeps counter bits 10:8
      pc = (pc & 12'h700) | acc;
      run(12'h022, fc(4, 3));
      pc = (pc & 12'h700) | ((pc + acc) & 8'hFF);
      run(12'h1E2, fc(4, 3));
      sv = $random(seed);
      acc = sv[31:27];
      st = sv[26:19];
      fsp = sv[18:11];
      pc = sv[10:0];
      wr(32'h0000_0024, sv);
      run(OP_INT_EXIT, fc(2, 3));
      // Same image again, so the added value is the same either way
      wr(32'h0000_0024, sv);
      rtc = (rtc + acc) & 8'hFF;
      run(OP_INT_EXIT_AD, fc(2, 3));
      rchk("rtc", 32'h0000_001C, rtc);
      wr(32'h0000_0020, 5);
      pcl = 0;
      st = (st | 8'h10) & 8'hF7;
      pc = (pc + 1) & 12'h7FF;
      run(OP_POWER_DOWN, 1);
      chk("osc_stop", 1, osc_stop);
      chk("prescaler clear", turbo, pcl);
      rchk("watchdog", 32'h0000_0020, 0);
      wr(32'h0000_0020, 0);
      // Let the clear settle past the write edge
      #1;
      chk("osc_stop", 0, osc_stop);
    end
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule : test_program_system_control_decode
